/* rtl/cps_pkg.sv */
// constants and types for the clock prescaler and bus strobe block
// Functional notes
// R01: outside party holds reset pin high two machine cycles with oscillator running
// R02: watchdog reset turns reset pin into output driving reset level
// R03: address latch pulse runs at osc/6 standard, osc/3 double speed
// R04: each external data access omits exactly one address latch pulse
// R05: auxiliary bit 0 set stops address latch pulse during internal fetches
// R06: external code execution asserts program fetch strobe twice per machine cycle
// R07: data access skips two fetch strobes, uses read or write strobe instead
// R08: program fetch strobe stays inactive for internal code fetches
// R09: data write strobe on port 3 bit 6, read strobe on bit 7
// R10: outside party holds fetch select low for external code in low range
// R11: with security level 1, fetch select latched at reset, later changes ignored
// R12: prescaler between oscillator and core, CPU and peripheral clocks identical
// R13: reset loads reload FFh, clocks osc/2, oscillator chosen as clock output
// R14: any reload value FFh down to 00h accepted as division setting
// R15: reload 00h divides by 1020 standard, 510 double speed
// R16: reload FFh divides by 2 standard, by 1 double speed
// R17: reload register eight bits wide, resets all ones, not bit addressable
// R18: double speed bit picks 6 or 12 periods; reset from config byte
// R19: double speed change applied only on rising edge of osc/2
// R20: end point ratios exact; intermediate ratios linear between them
// R21: new reload takes effect at next prescaler terminal count
`default_nettype none
package cps_pkg;
  localparam logic [7:0]  AUX_CTRL_ADDR    = 8'h8E;
  localparam logic [7:0]  CLK_SPEED_ADDR   = 8'h8F;
  localparam logic [7:0]  CLK_RELOAD_ADDR  = 8'h97;
  localparam logic [7:0]  BLK_STATUS_ADDR  = 8'hC0;
  localparam logic [7:0]  AUX_CTRL_RST     = 8'h00;
  localparam logic [7:0]  CLK_SPEED_RST    = 8'h00;
  localparam logic [7:0]  CLK_RELOAD_RST   = 8'hFF;
  localparam logic [7:0]  CLK_SPEED_MASK   = 8'h7F;
  localparam int          AUX_ALE_OFF_BIT  = 0;
  localparam int          X2_BIT           = 0;
  localparam logic [2:0]  PH_LAST          = 3'h5;
  localparam logic [2:0]  PH_ALE_A         = 3'h0;
  localparam logic [2:0]  PH_ALE_B         = 3'h3;
  localparam logic [1:0]  RESET_HOLD_MC    = 2'h2;
  localparam logic [3:0]  WDT_DRIVE_MC     = 4'h8;
  localparam int          DIV_W            = 11;
  localparam logic [DIV_W-1:0] DIV_RST     = 11'h002;
  typedef enum logic [1:0] {
    CPS_BUS_IDLE = 2'b00,
    CPS_BUS_CODE = 2'b01,
    CPS_BUS_DATA = 2'b11
  } cps_bus_e;
endpackage : cps_pkg
`default_nettype wire

/* rtl/cps_sync.sv */
// two flip-flop synchroniser for pin inputs
`default_nettype none
module cps_sync
  import cps_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // no reset: pins keep flowing during reset so the fetch select latch sees them
      always_ff @(posedge core_clk) begin
        meta_q[g] <= async_i[g];
        sync_o[g] <= meta_q[g];
      end
    end
  endgenerate
endmodule : cps_sync
`default_nettype wire

/* rtl/cps_prescaler.sv */
// oscillator prescaler producing the cpu and peripheral clock enable
`default_nettype none
module cps_prescaler
  import cps_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reload,
  input  wire logic       x2_req,
  output logic            tick_q,
  output logic            x2_q
);
  logic             half_q;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] period_q;
  logic [DIV_W-1:0] base;
  logic [DIV_W-1:0] period_d;

  // FFh gives 1, else 2*(255-r): 00h gives 510 (x2) or 1020 (standard)
  always_comb begin
    if (reload == 8'hFF) base = 11'h001;               // R16
    else base = {2'b00, 8'hFF - reload, 1'b0};         // R14 R15 R20
    period_d = x2_q ? base : {base[DIV_W-2:0], 1'b0};
  end

  always_ff @(posedge core_clk) begin
    if (srst) half_q <= 1'b0;
    else half_q <= ~half_q;
  end

  // sampled only as osc/2 rises, avoiding a clock glitch
  always_ff @(posedge core_clk) begin
    if (srst) x2_q <= 1'b0;
    else if (!half_q) x2_q <= x2_req;                  // R18 R19
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q    <= '0;
      period_q <= DIV_RST;                             // R13
      tick_q   <= 1'b0;
    end else if (cnt_q >= period_q - 11'h001) begin
      cnt_q    <= '0;
      period_q <= period_d;                            // R21
      tick_q   <= 1'b1;                                // R12
    end else begin
      cnt_q    <= cnt_q + 11'h001;
      tick_q   <= 1'b0;
    end
  end

  a_x2_half_edge: assert property (@(posedge core_clk) disable iff (srst) // R19
    $changed(x2_q) |-> $past(half_q) == 1'b0)
    else $error("double speed changed off the osc/2 rising edge");

  a_full_rate: assert property (@(posedge core_clk) disable iff (srst) // R16
    (period_q == 11'h001 && tick_q && $past(period_q) == 11'h001) |-> ##1 tick_q)
    else $error("undivided clock enable missed a cycle");
endmodule : cps_prescaler
`default_nettype wire

/* rtl/cps_clock_bus.sv */
// clock control registers, machine cycle sequencer and external bus strobes
//
// The plain strobed port was decided locally.
`default_nettype none
module cps_clock_bus
  import cps_pkg::*;
#(
  parameter logic [15:0] ROM_TOP = 16'h3FFF
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        hcb_double_speed,
  input  wire logic        security_level1,
  input  wire logic        external_fetch_select_n,
  input  wire logic [15:0] code_addr,
  input  wire logic        xdata_rd_req,
  input  wire logic        xdata_wr_req,
  input  wire logic        wdt_reset_req,
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_n,
  output logic             sys_reset,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             oscillator_select_signal,
  output logic             address_latch,
  output logic             program_fetch_strobe_n,
  output logic             xdata_wr_strobe_n,
  output logic             xdata_rd_strobe_n,
  output logic             xdata_busy
);
  logic [7:0] aux_q;
  logic [7:0] speed_q;
  logic [7:0] reload_q;
  logic [7:0] rdata_q;
  logic       tick;
  logic       x2_eff;
  logic [1:0] pins_sync;
  logic       rst_in;
  logic       ea_n_in;
  logic [2:0] ph_q;
  logic       mc_end;
  cps_bus_e   st_q;
  cps_bus_e   st_d;
  logic       pend_q;
  logic       pend_wr_q;
  logic       dir_wr_q;
  logic [1:0] hold_q;
  logic       sys_reset_q;
  logic [3:0] drive_q;
  logic       ea_lat_q;
  logic       ea_eff;
  logic       fetch_ext;
  logic       ale_q;
  logic       ale_d;
  logic       program_fetch_strobe_n_q;
  logic       program_fetch_strobe_d;
  logic       rd_n_q;
  logic       wr_n_q;
  logic       strobe_ph;
  logic       rst_o_q;
  logic       rst_oe_n_q;
  logic       clk_sel_q;
  logic       clk_en_q;
  logic       busy_q;

  cps_sync #(
    .W (2)
  ) u_sync (
    .core_clk (core_clk),
    .async_i  ({rst_pin_i, external_fetch_select_n}),
    .sync_o   (pins_sync)
  );

  assign rst_in  = pins_sync[1];
  assign ea_n_in = pins_sync[0];

  cps_prescaler u_prescaler (
    .core_clk (core_clk),
    .srst     (srst),
    .reload   (reload_q),
    .x2_req   (speed_q[X2_BIT]),
    .tick_q   (tick),
    .x2_q     (x2_eff)
  );

  // ---------------- register file ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aux_q <= AUX_CTRL_RST;
    end else if (reg_wr && reg_addr == AUX_CTRL_ADDR) begin
      aux_q <= reg_wdata;
    end
  end

  // double speed bit reloaded from the config byte on every srst, not on the pin reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      speed_q <= CLK_SPEED_RST | {7'h00, hcb_double_speed};           // R18
    end else if (reg_wr && reg_addr == CLK_SPEED_ADDR) begin
      speed_q <= reg_wdata & CLK_SPEED_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reload_q <= CLK_RELOAD_RST;                                      // R13 R17
    end else if (reg_wr && reg_addr == CLK_RELOAD_ADDR) begin
      reload_q <= reg_wdata;                                           // R14
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        AUX_CTRL_ADDR:   rdata_q <= aux_q;
        CLK_SPEED_ADDR:  rdata_q <= speed_q;
        CLK_RELOAD_ADDR: rdata_q <= reload_q;
        BLK_STATUS_ADDR: rdata_q <= {4'h0, busy_q, sys_reset_q, ea_eff, x2_eff};
        default:         rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ---------------- clock outputs ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clk_sel_q <= 1'b0;                                               // R13
      clk_en_q  <= 1'b0;
    end else begin
      clk_sel_q <= 1'b0;
      clk_en_q  <= tick;                                               // R12
    end
  end

  // ---------------- machine cycle phases ----------------
  assign mc_end = tick && (ph_q == PH_LAST);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ph_q <= 3'h0;
    end else if (tick) begin
      ph_q <= mc_end ? 3'h0 : ph_q + 3'h1;
    end
  end

  // ---------------- reset pin ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_q      <= 2'h0;
      sys_reset_q <= 1'b0;
    end else if (!rst_in) begin
      hold_q      <= 2'h0;
      sys_reset_q <= 1'b0;
    end else if (mc_end && hold_q != RESET_HOLD_MC) begin
      hold_q      <= hold_q + 2'h1;                                    // R01
      sys_reset_q <= (hold_q + 2'h1) == RESET_HOLD_MC;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      drive_q    <= 4'h0;
      rst_o_q    <= 1'b0;
      rst_oe_n_q <= 1'b1;
    end else begin
      if (wdt_reset_req) begin
        drive_q <= WDT_DRIVE_MC;
      end else if (mc_end && drive_q != 4'h0) begin
        drive_q <= drive_q - 4'h1;
      end
      rst_o_q    <= wdt_reset_req || drive_q != 4'h0;                  // R02
      rst_oe_n_q <= !(wdt_reset_req || drive_q != 4'h0);
    end
  end

  // ---------------- external fetch select ----------------
  always_ff @(posedge core_clk) begin
    if (srst || sys_reset_q) begin
      ea_lat_q <= ea_n_in;                                             // R11
    end
  end

  assign ea_eff    = security_level1 ? ea_lat_q : ea_n_in;             // R11
  assign fetch_ext = !ea_eff || (code_addr > ROM_TOP);                 // R10

  // ---------------- data access requests ----------------
  // a new request in the cycle the old one is taken is kept
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_q    <= 1'b0;
      pend_wr_q <= 1'b0;
    end else if (xdata_rd_req || xdata_wr_req) begin
      pend_q    <= 1'b1;
      pend_wr_q <= xdata_wr_req;
    end else if (mc_end) begin
      pend_q    <= 1'b0;
    end
  end

  // ---------------- bus cycle sequencer ----------------
  always_comb begin
    if (pend_q) st_d = CPS_BUS_DATA;
    else if (fetch_ext) st_d = CPS_BUS_CODE;
    else st_d = CPS_BUS_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q     <= CPS_BUS_IDLE;
      dir_wr_q <= 1'b0;
      busy_q   <= 1'b0;
    end else if (mc_end) begin
      st_q     <= st_d;
      dir_wr_q <= pend_wr_q;
      busy_q   <= pend_q;
    end
  end

  // ---------------- strobe decode ----------------
  always_comb begin
    ale_d     = 1'b0;
    program_fetch_strobe_d    = 1'b0;
    strobe_ph = (ph_q != 3'h0) && (ph_q != PH_LAST);
    case (st_q)
      CPS_BUS_IDLE: begin
        ale_d = !aux_q[AUX_ALE_OFF_BIT] &&
                (ph_q == PH_ALE_A || ph_q == PH_ALE_B);                // R03 R05
      end
      CPS_BUS_CODE: begin
        ale_d  = (ph_q == PH_ALE_A || ph_q == PH_ALE_B);               // R03
        program_fetch_strobe_d = (ph_q != PH_ALE_A && ph_q != PH_ALE_B);               // R06
      end
      CPS_BUS_DATA: begin
        ale_d = (ph_q == PH_ALE_A);                                    // R04
      end
      default: begin
        ale_d  = 1'b0;
        program_fetch_strobe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst || sys_reset_q) begin
      ale_q    <= 1'b0;
      program_fetch_strobe_n_q <= 1'b1;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
    end else begin
      ale_q    <= ale_d;
      program_fetch_strobe_n_q <= !program_fetch_strobe_d;                                             // R08
      rd_n_q   <= !(st_q == CPS_BUS_DATA && !dir_wr_q && strobe_ph);   // R07 R09
      wr_n_q   <= !(st_q == CPS_BUS_DATA && dir_wr_q && strobe_ph);    // R07 R09
    end
  end

  assign reg_rdata                = rdata_q;
  assign cpu_clk_en               = clk_en_q;
  assign periph_clk_en            = clk_en_q;
  assign oscillator_select_signal = clk_sel_q;
  assign rst_pin_o                = rst_o_q;
  assign rst_pin_oe_n             = rst_oe_n_q;
  assign sys_reset                = sys_reset_q;
  assign address_latch            = ale_q;
  assign program_fetch_strobe_n   = program_fetch_strobe_n_q;
  assign xdata_wr_strobe_n        = wr_n_q;
  assign xdata_rd_strobe_n        = rd_n_q;
  assign xdata_busy               = busy_q;

  // ---------------- checks ----------------
  a_data_ale_skip: assert property (@(posedge core_clk) disable iff (srst) // R04
    (st_q == CPS_BUS_DATA && ph_q == PH_ALE_B && !sys_reset_q) |-> ##1 !ale_q)
    else $error("address latch pulse not omitted in data cycle");

  a_ale_inhibit_idle: assert property (@(posedge core_clk) disable iff (srst) // R05
    (st_q == CPS_BUS_IDLE && aux_q[AUX_ALE_OFF_BIT]) |-> ##1 !ale_q)
    else $error("address latch pulse during internal fetch while inhibited");

  a_ale_rate_code: assert property (@(posedge core_clk) disable iff (srst) // R03
    (st_q == CPS_BUS_CODE && ph_q == PH_ALE_B && !sys_reset_q) |-> ##1 ale_q)
    else $error("address latch pulse missing in code cycle");

  a_program_fetch_strobe_code_on: assert property (@(posedge core_clk) disable iff (srst) // R06
    (st_q == CPS_BUS_CODE && ph_q == 3'h4 && !sys_reset_q) |-> ##1 !program_fetch_strobe_n_q)
    else $error("fetch strobe missing in external code cycle");

  a_program_fetch_strobe_internal: assert property (@(posedge core_clk) disable iff (srst) // R08
    (st_q != CPS_BUS_CODE) |-> ##1 program_fetch_strobe_n_q)
    else $error("fetch strobe active outside external code cycle");

  a_data_rd_strobe: assert property (@(posedge core_clk) disable iff (srst) // R07
    (st_q == CPS_BUS_DATA && !dir_wr_q && ph_q == 3'h2 && !sys_reset_q)
      |-> ##1 (!rd_n_q && wr_n_q && program_fetch_strobe_n_q))
    else $error("read strobe wrong in data read cycle");

  a_wdt_drive_pin: assert property (@(posedge core_clk) disable iff (srst) // R02
    wdt_reset_req |-> ##1 (!rst_pin_oe_n && rst_pin_o) [*2])
    else $error("reset pin not driven after watchdog reset");

  a_reset_two_mc: assert property (@(posedge core_clk) disable iff (srst) // R01
    (rst_in && mc_end && hold_q == 2'h1) |-> ##1 sys_reset_q)
    else $error("reset not taken after two machine cycles");

  a_ea_latched: assert property (@(posedge core_clk) disable iff (srst) // R11
    (!sys_reset_q && !$past(sys_reset_q) && !$past(srst)) |-> $stable(ea_lat_q))
    else $error("latched fetch select changed outside reset");

  a_data_wr_strobe: assert property (@(posedge core_clk) disable iff (srst) // R07 R09
    (st_q == CPS_BUS_DATA && dir_wr_q && ph_q == 3'h2 && !sys_reset_q)
      |-> ##1 (!wr_n_q && rd_n_q && program_fetch_strobe_n_q))
    else $error("write strobe wrong in data write cycle");

  a_data_cycle_start: assert property (@(posedge core_clk) disable iff (srst) // R04 R07
    (mc_end && pend_q) |-> ##1 (st_q == CPS_BUS_DATA && xdata_busy))
    else $error("pending data access not started at machine cycle end");

  a_ale_phase_zero: assert property (@(posedge core_clk) disable iff (srst) // R03
    (st_q != CPS_BUS_IDLE && ph_q == PH_ALE_A && !sys_reset_q) |-> ##1 ale_q)
    else $error("address latch pulse missing in phase zero");

  a_ale_idle_on: assert property (@(posedge core_clk) disable iff (srst) // R05
    (st_q == CPS_BUS_IDLE && !aux_q[AUX_ALE_OFF_BIT] && ph_q == PH_ALE_B && !sys_reset_q)
      |-> ##1 ale_q)
    else $error("address latch pulse missing while not inhibited");

  a_code_select: assert property (@(posedge core_clk) disable iff (srst) // R10
    (mc_end && !pend_q && fetch_ext) |-> ##1 (st_q == CPS_BUS_CODE))
    else $error("external code cycle not chosen");

  a_reset_strobes_off: assert property (@(posedge core_clk) disable iff (srst) // R01
    sys_reset_q |-> ##1 (!ale_q && program_fetch_strobe_n_q && rd_n_q && wr_n_q))
    else $error("bus strobe active during internal reset");

  a_wdt_pin_release: assert property (@(posedge core_clk) disable iff (srst) // R02
    (drive_q == 4'h0 && !wdt_reset_req) |-> ##1 rst_pin_oe_n)
    else $error("reset pin still driven after watchdog drive time");
endmodule : cps_clock_bus
`default_nettype wire

/* dv/cps_ext_mem.sv */
// far side model: external memory watching the bus strobes, plus the reset pin net
`default_nettype none
module cps_ext_mem (
  input  wire logic        core_clk,
  input  wire logic        clr,
  input  wire logic        hold_rst,
  input  wire logic        address_latch,
  input  wire logic        program_fetch_strobe_n,
  input  wire logic        xdata_wr_strobe_n,
  input  wire logic        xdata_rd_strobe_n,
  input  wire logic        rst_pin_o,
  input  wire logic        rst_pin_oe_n,
  output logic             rst_pin_i,
  output logic      [15:0] n_latch,
  output logic      [15:0] n_fetch,
  output logic      [15:0] n_rd,
  output logic      [15:0] n_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lat_p = 1'b0;
  logic fet_p = 1'b1;
  logic rd_p  = 1'b1;
  logic wr_p  = 1'b1;
  // pin has a pull-down; the outside capacitor holds it high on request
  assign rst_pin_i = !rst_pin_oe_n ? rst_pin_o : hold_rst;
  // count activations as leading edges of each strobe
  always @(posedge core_clk) begin
    if (clr) begin
      n_latch <= 16'h0000;
      n_fetch <= 16'h0000;
      n_rd    <= 16'h0000;
      n_wr    <= 16'h0000;
    end else begin
      n_latch <= n_latch + {15'h0000, address_latch & !lat_p};
      n_fetch <= n_fetch + {15'h0000, !program_fetch_strobe_n & fet_p};
      n_rd    <= n_rd + {15'h0000, !xdata_rd_strobe_n & rd_p};
      n_wr    <= n_wr + {15'h0000, !xdata_wr_strobe_n & wr_p};
    end
    lat_p <= address_latch;
    fet_p <= program_fetch_strobe_n;
    rd_p  <= xdata_rd_strobe_n;
    wr_p  <= xdata_wr_strobe_n;
  end
endmodule : cps_ext_mem
`default_nettype wire

/* dv/tb_clock_prescaler_bus_strobes.sv */
// self-checking bench for the clock prescaler and bus strobe block
`default_nettype none
module tb_clock_prescaler_bus_strobes
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ROM_TOP_T = 16'h3FFF;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        hcb_ds = 1'b0;
  logic        sec1 = 1'b0;
  logic        fsel_n = 1'b1;
  logic [15:0] code_addr = 16'h0000;
  logic        rd_req = 1'b0;
  logic        wr_req = 1'b0;
  logic        wdt_req = 1'b0;
  logic        clr = 1'b0;
  logic        hold_rst = 1'b0;
  logic        rst_i, rst_o, rst_oe_n, sys_reset, cpu_en, per_en;
  logic        osc_sel, latch, fetch_n, wr_n, rd_n, busy;
  logic [7:0]  reg_rdata;
  logic [15:0] n_latch, n_fetch, n_rd, n_wr, n;
  logic [7:0]  exp_q[$];
  logic        rd_pend = 1'b0;
  logic [15:0] nb = 16'h0000;
  int          seed = 32'hA535DECE;
  logic [31:0] rnd;
  int          num_errors = 0;
  int          checked = 0;
  int          pe_diff = 0;
  int          i;
  logic [7:0]  rl_t [5] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFE};
  logic        x2_t [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [15:0] per_t [5] = '{16'h0002, 16'h0001, 16'h03FC, 16'h01FE, 16'h0004};

  always #10 core_clk = ~core_clk;

  cps_clock_bus #(.ROM_TOP(ROM_TOP_T)) uut (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hcb_double_speed(hcb_ds),
    .security_level1(sec1), .external_fetch_select_n(fsel_n), .code_addr(code_addr),
    .xdata_rd_req(rd_req), .xdata_wr_req(wr_req), .wdt_reset_req(wdt_req),
    .rst_pin_i(rst_i), .rst_pin_o(rst_o), .rst_pin_oe_n(rst_oe_n), .sys_reset(sys_reset),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .oscillator_select_signal(osc_sel),
    .address_latch(latch), .program_fetch_strobe_n(fetch_n), .xdata_wr_strobe_n(wr_n),
    .xdata_rd_strobe_n(rd_n), .xdata_busy(busy));

  cps_ext_mem mem (
    .core_clk(core_clk), .clr(clr), .hold_rst(hold_rst), .address_latch(latch),
    .program_fetch_strobe_n(fetch_n), .xdata_wr_strobe_n(wr_n), .xdata_rd_strobe_n(rd_n),
    .rst_pin_o(rst_o), .rst_pin_oe_n(rst_oe_n), .rst_pin_i(rst_i), .n_latch(n_latch),
    .n_fetch(n_fetch), .n_rd(n_rd), .n_wr(n_wr));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : reg_read

  // clocks from one clock enable to the next
  task automatic gap();
    n = 16'h0000;
    do begin
      @(posedge core_clk);
      n++;
    end while (cpu_en !== 1'b1 && n < 16'h0800);
  endtask : gap

  // strobe counts over ten standard machine cycles, optional data access inside
  task automatic window(input logic [1:0] req, input logic [15:0] el, ef, er, ew);
    repeat (24) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (12) @(posedge core_clk);
    rd_req <= req[0];
    wr_req <= req[1];
    @(posedge core_clk);
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    repeat (108) @(posedge core_clk);
    check("latch_count", el, n_latch);
    check("fetch_count", ef, n_fetch);
    check("read_count", er, n_rd);
    check("write_count", ew, n_wr);
    check("busy_cycles", (req != 2'b00) ? 16'h000C : 16'h0000, nb);
  endtask : window

  // read data stand only in the cycle after the read strobe
  always @(posedge core_clk) begin
    if (rd_pend) begin
      check("reg_rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
    end
    if (per_en !== cpu_en) pe_diff++;
    nb <= clr ? 16'h0000 : nb + {15'h0000, busy === 1'b1};
    rd_pend <= reg_rd;
  end

  initial begin
    #(40000 * 20);
    num_errors++;
    $display("Error run_time expected finish seen timeout");
    final_report();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check("osc_select", 16'h0000, {15'h0000, osc_sel});
    check("rst_pin_oe_n", 16'h0001, {15'h0000, rst_oe_n});
    reg_read(CLK_RELOAD_ADDR, CLK_RELOAD_RST);
    reg_read(AUX_CTRL_ADDR, AUX_CTRL_RST);
    reg_read(CLK_SPEED_ADDR, CLK_SPEED_RST);
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      reg_write(CLK_RELOAD_ADDR, rnd[7:0]);
      reg_read(CLK_RELOAD_ADDR, rnd[7:0]);
    end
    reg_write(CLK_SPEED_ADDR, 8'hFE);
    reg_read(CLK_SPEED_ADDR, 8'hFE & CLK_SPEED_MASK);
    reg_write(8'h55, 8'hA5);
    reg_read(8'h55, 8'h00);
    reg_read(BLK_STATUS_ADDR, 8'h02);
    $display("test registers done");
    for (i = 0; i < 5; i++) begin
      reg_write(CLK_RELOAD_ADDR, rl_t[i]);
      reg_write(CLK_SPEED_ADDR, {7'h00, x2_t[i]});
      repeat (3) gap();
      check("tick_period", per_t[i], n);
    end
    check("clk_en_pair", 16'h0000, pe_diff[15:0]);
    $display("test prescaler done");
    reg_write(CLK_RELOAD_ADDR, 8'hFF);
    reg_write(CLK_SPEED_ADDR, 8'h00);
    rnd = $random(seed);
    code_addr <= rnd[15:0] & ROM_TOP_T;
    window(2'b00, 16'h0014, 16'h0000, 16'h0000, 16'h0000);
    window(2'b01, 16'h0013, 16'h0000, 16'h0001, 16'h0000);
    reg_write(AUX_CTRL_ADDR, 8'h01);
    window(2'b00, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    fsel_n <= 1'b0;
    window(2'b00, 16'h0014, 16'h0014, 16'h0000, 16'h0000);
    reg_write(AUX_CTRL_ADDR, 8'h00);
    window(2'b01, 16'h0013, 16'h0012, 16'h0001, 16'h0000);
    window(2'b10, 16'h0013, 16'h0012, 16'h0000, 16'h0001);
    fsel_n <= 1'b1;
    code_addr <= rnd[15:0] | 16'h4000;
    window(2'b00, 16'h0014, 16'h0014, 16'h0000, 16'h0000);
    code_addr <= rnd[15:0] & ROM_TOP_T;
    reg_write(CLK_SPEED_ADDR, 8'h01);
    window(2'b00, 16'h0028, 16'h0000, 16'h0000, 16'h0000);
    $display("test bus strobes done");
    sec1 <= 1'b1;
    hcb_ds <= 1'b1;
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    fsel_n <= 1'b0;
    reg_read(CLK_SPEED_ADDR, 8'h01);
    reg_write(CLK_SPEED_ADDR, 8'h00);
    window(2'b00, 16'h0014, 16'h0000, 16'h0000, 16'h0000);
    sec1 <= 1'b0;
    window(2'b00, 16'h0014, 16'h0014, 16'h0000, 16'h0000);
    $display("test fetch select latch done");
    hold_rst <= 1'b1;
    repeat (30) @(posedge core_clk);
    for (i = 0; i < 60 && sys_reset !== 1'b1; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    check("sys_reset", 16'h0001, {15'h0000, sys_reset});
    check("latch_in_reset", 16'h0000, {15'h0000, latch});
    check("fetch_in_reset", 16'h0001, {15'h0000, fetch_n});
    hold_rst <= 1'b0;
    for (i = 0; i < 100 && sys_reset !== 1'b0; i++) @(posedge core_clk);
    check("sys_reset_release", 16'h0000, {15'h0000, sys_reset});
    wdt_req <= 1'b1;
    @(posedge core_clk);
    wdt_req <= 1'b0;
    for (i = 0; i < 30 && rst_oe_n !== 1'b0; i++) @(posedge core_clk);
    check("rst_pin_oe_n", 16'h0000, {15'h0000, rst_oe_n});
    check("rst_pin_o", 16'h0001, {15'h0000, rst_o});
    for (i = 0; i < 300 && rst_oe_n !== 1'b1; i++) @(posedge core_clk);
    check("rst_pin_release", 16'h0001, {15'h0000, rst_oe_n});
    $display("test reset pin done");
    final_report();
  end
endmodule : tb_clock_prescaler_bus_strobes
`default_nettype wire
